/* include/mrb_defines.vh */
// What this block does
// R1: device holds mode registers for configuration and status
// R2: reads and writes only via mode register commands
// R3: each register is read-only, write-only or read/write
// R4: controller writes zero into reserved bits
// R5: reserved bits read back as zero
// R6: bad-register read still strobes, data undefined
// R7: controller never writes reserved register addresses
// R8: writes to read-only registers change nothing
// R9: device info register layout at index zero
// R10: auto-init bit high while init runs
// R11: zq self-test field set after calibration
// R12: reset register write restarts initialisation
// R13: eight-bit index, unassigned addresses act reserved
`ifndef MRB_DEFINES_VH
`define MRB_DEFINES_VH
`define MRB_IDX_DEV_INFO    8'h00
`define MRB_IDX_FEAT_ONE    8'h01
`define MRB_IDX_FEAT_TWO    8'h02
`define MRB_IDX_IO_CFG      8'h03
`define MRB_IDX_REFRESH     8'h04
`define MRB_IDX_MAKER       8'h05
`define MRB_IDX_REV_ONE     8'h06
`define MRB_IDX_REV_TWO     8'h07
`define MRB_IDX_WIDTH_DENS  8'h08
`define MRB_IDX_TEST_MODE   8'h09
`define MRB_IDX_IO_CAL      8'h0a
`define MRB_IDX_PA_BANK     8'h10
`define MRB_IDX_PA_SEG      8'h11
`define MRB_IDX_DQ_PAT_A    8'h20
`define MRB_IDX_DQ_PAT_B    8'h28
`define MRB_IDX_RESET       8'h3f
`define MRB_BIT_AUTO_INIT   0
`define MRB_BIT_KIND        1
`define MRB_BIT_DATA_INV    2
`define MRB_ZQ_LSB          3
`define MRB_ZQ_MSB          4
`define MRB_ZQ_NOT_SUPP     2'h0
`define MRB_FEAT_ONE_RST    8'h22
`define MRB_ZERO_BYTE       8'h00
`define MRB_UNDEF_BYTE      8'h00
`define MRB_INIT_NS         10000
`define MRB_ZQ_NS           1000
`define MRB_CLK_NS          20
`define MRB_INIT_CYC        ((`MRB_INIT_NS + `MRB_CLK_NS - 1) / `MRB_CLK_NS)
`define MRB_ZQ_CYC          ((`MRB_ZQ_NS + `MRB_CLK_NS - 1) / `MRB_CLK_NS)
`endif

/* verilog/mrb_mode_register_bank.v */
`timescale 1ns/1ps
`default_nettype none
`include "mrb_defines.vh"
module mrb_mode_register_bank
#(
  parameter [7:0]  maker_id    = 8'h5a,  // arbitrary value
  parameter [7:0]  rev_one_id  = 8'h01,  // arbitrary value
  parameter [7:0]  rev_two_id  = 8'h00,  // arbitrary value
  parameter [7:0]  width_dens  = 8'h14,
  parameter [7:0]  dq_pat_a    = 8'h55,
  parameter [7:0]  dq_pat_b    = 8'h3c,
  parameter [1:0]  zq_result   = 2'h3,
  parameter        kind_nvm    = 1'b0,
  parameter [15:0] init_cycles = `MRB_INIT_CYC,
  parameter [15:0] zq_cycles   = `MRB_ZQ_CYC
)
(
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       mode_reg_read_cmd,
  input  wire       mode_reg_write_cmd,
  input  wire [7:0] reg_index,
  input  wire [7:0] wr_data,
  input  wire [7:0] refresh_status,
  output reg        rd_valid,
  output reg  [7:0] rd_data,
  output reg        rd_strobe_toggle,
  output reg        auto_init_busy,
  output reg        reset_pulse,
  output reg  [7:0] device_feature_one,
  output reg  [7:0] device_feature_two,
  output reg  [7:0] io_configuration,
  output reg  [7:0] vendor_test_mode,
  output reg  [7:0] partial_array_bank_mask,
  output reg  [7:0] partial_array_segment_mask,
  output reg        zq_cal_start
);

  // access class: 2'b01 read-only, 2'b10 write-only, 2'b00 reserved
  function [1:0] access_class;
    input [7:0] idx;
    begin
      case (idx)
        `MRB_IDX_DEV_INFO, `MRB_IDX_REFRESH, `MRB_IDX_MAKER,
        `MRB_IDX_REV_ONE, `MRB_IDX_REV_TWO, `MRB_IDX_WIDTH_DENS,
        `MRB_IDX_DQ_PAT_A, `MRB_IDX_DQ_PAT_B:
          access_class = 2'h1; // R3
        `MRB_IDX_FEAT_ONE, `MRB_IDX_FEAT_TWO, `MRB_IDX_IO_CFG,
        `MRB_IDX_TEST_MODE, `MRB_IDX_IO_CAL, `MRB_IDX_PA_BANK,
        `MRB_IDX_PA_SEG, `MRB_IDX_RESET:
          access_class = 2'h2; // R3
        default:
          access_class = 2'h0; // R13
      endcase
    end
  endfunction

  localparam [2:0] st_init = 3'b001;
  localparam [2:0] st_idle = 3'b010;
  localparam [2:0] st_zq   = 3'b100;

  reg  [2:0]  state;
  reg  [15:0] count;
  reg  [1:0]  zq_field;
  reg  [2:0]  next_state;
  reg  [15:0] next_count;
  reg  [1:0]  next_zq_field;
  reg  [7:0]  next_feature_one;
  reg  [7:0]  next_feature_two;
  reg  [7:0]  next_io_config;
  reg  [7:0]  next_test_mode;
  reg  [7:0]  next_bank_mask;
  reg  [7:0]  next_segment_mask;
  reg  [7:0]  next_rd_data;
  wire [1:0]  cls = access_class(reg_index);
  wire        wr_ok = mode_reg_write_cmd && (cls == 2'h2); // R8 R13
  wire        wr_reset = wr_ok && (reg_index == `MRB_IDX_RESET);
  wire        wr_cal = wr_ok && (reg_index == `MRB_IDX_IO_CAL);
  wire [7:0]  info_byte;

  // upper bits of the info register stay zero
  assign info_byte = {3'h0, zq_field, 1'b0, kind_nvm, auto_init_busy}; // R5 R9

  always @*
  begin
    next_state = state;
    next_count = count;
    case (state)
      st_init:
      begin
        if (count == 16'h0000)
          next_state = st_idle; // R10
        else
          next_count = count - 16'h0001;
      end
      st_idle:
      begin
        if (wr_cal)
        begin
          next_state = st_zq;
          next_count = zq_cycles - 16'h0001;
        end
      end
      st_zq:
      begin
        if (count == 16'h0000)
          next_state = st_idle;
        else
          next_count = count - 16'h0001;
      end
      default:
        next_state = st_init;
    endcase
    // reset register wins over every other state
    if (wr_reset)
    begin
      next_state = st_init; // R12
      next_count = init_cycles - 16'h0001;
    end
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state          <= st_init;
      count          <= init_cycles - 16'h0001;
      auto_init_busy <= 1'b1;
    end
    else
    begin
      state          <= next_state;
      count          <= next_count;
      auto_init_busy <= (next_state == st_init); // R10
    end
  end

  // zq field only reports once a calibration started by a write to the io cal register completes
  // a reset write restarts init, so it outranks a finishing calibration
  always @*
  begin
    next_zq_field = zq_field;
    if (wr_reset)
      next_zq_field = `MRB_ZQ_NOT_SUPP; // R12
    else if (state == st_zq && count == 16'h0000)
      next_zq_field = zq_result; // R11
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
      zq_field <= `MRB_ZQ_NOT_SUPP;
    else
      zq_field <= next_zq_field;
  end

  // write decode kept apart so each register has one next value
  always @*
  begin
    next_feature_one  = device_feature_one;
    next_feature_two  = device_feature_two;
    next_io_config    = io_configuration;
    next_test_mode    = vendor_test_mode;
    next_bank_mask    = partial_array_bank_mask;
    next_segment_mask = partial_array_segment_mask;
    if (wr_reset)
    begin
      // reset register also restores the configuration
      next_feature_one  = `MRB_FEAT_ONE_RST; // R12
      next_feature_two  = `MRB_ZERO_BYTE;
      next_io_config    = `MRB_ZERO_BYTE;
      next_test_mode    = `MRB_ZERO_BYTE;
      next_bank_mask    = `MRB_ZERO_BYTE;
      next_segment_mask = `MRB_ZERO_BYTE;
    end
    else if (wr_ok)
    begin
      case (reg_index) // R2 R1
        `MRB_IDX_FEAT_ONE:
        begin
          next_feature_one = wr_data;
        end
        `MRB_IDX_FEAT_TWO:
        begin
          next_feature_two = wr_data;
        end
        `MRB_IDX_IO_CFG:
        begin
          next_io_config = wr_data;
        end
        `MRB_IDX_TEST_MODE:
        begin
          next_test_mode = wr_data;
        end
        `MRB_IDX_PA_BANK:
        begin
          next_bank_mask = wr_data;
        end
        `MRB_IDX_PA_SEG:
        begin
          next_segment_mask = wr_data;
        end
        default:
        begin
          // calibration code and reset trigger keep no stored byte
          next_segment_mask = partial_array_segment_mask;
        end
      endcase
    end
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      device_feature_one         <= `MRB_FEAT_ONE_RST;
      device_feature_two         <= `MRB_ZERO_BYTE;
      io_configuration           <= `MRB_ZERO_BYTE;
      vendor_test_mode           <= `MRB_ZERO_BYTE;
      partial_array_bank_mask    <= `MRB_ZERO_BYTE;
      partial_array_segment_mask <= `MRB_ZERO_BYTE;
    end
    else
    begin
      device_feature_one         <= next_feature_one;
      device_feature_two         <= next_feature_two;
      io_configuration           <= next_io_config;
      vendor_test_mode           <= next_test_mode;
      partial_array_bank_mask    <= next_bank_mask;
      partial_array_segment_mask <= next_segment_mask;
    end
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reset_pulse  <= 1'b0;
      zq_cal_start <= 1'b0;
    end
    else
    begin
      reset_pulse  <= wr_reset; // R12
      zq_cal_start <= wr_cal && (state == st_idle);
    end
  end

  // read data holds between reads so a late sampler still sees it
  always @*
  begin
    next_rd_data = rd_data;
    if (mode_reg_read_cmd)
    begin
      if (cls != 2'h1)
      begin
        next_rd_data = `MRB_UNDEF_BYTE; // R6 R13
      end
      else
      begin
        case (reg_index)
          `MRB_IDX_DEV_INFO:
          begin
            next_rd_data = info_byte;
          end
          `MRB_IDX_REFRESH:
          begin
            next_rd_data = refresh_status;
          end
          `MRB_IDX_MAKER:
          begin
            next_rd_data = maker_id;
          end
          `MRB_IDX_REV_ONE:
          begin
            next_rd_data = rev_one_id;
          end
          `MRB_IDX_REV_TWO:
          begin
            next_rd_data = rev_two_id;
          end
          `MRB_IDX_WIDTH_DENS:
          begin
            next_rd_data = width_dens;
          end
          `MRB_IDX_DQ_PAT_A:
          begin
            next_rd_data = dq_pat_a;
          end
          default:
          begin
            next_rd_data = dq_pat_b;
          end
        endcase
      end
    end
  end

  // read answer one cycle after the command
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rd_valid         <= 1'b0;
      rd_strobe_toggle <= 1'b0;
      rd_data          <= `MRB_ZERO_BYTE;
    end
    else
    begin
      rd_valid         <= mode_reg_read_cmd; // R2
      rd_strobe_toggle <= mode_reg_read_cmd; // R6
      rd_data          <= next_rd_data;
    end
  end

endmodule // mrb_mode_register_bank
`default_nettype wire

/* tb/mrb_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module mrb_monitor
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       mode_reg_read_cmd,
  input wire logic       mode_reg_write_cmd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] wr_data,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic       rd_strobe_toggle,
  input wire logic       auto_init_busy,
  input wire logic       reset_pulse,
  input wire logic [7:0] device_feature_one
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire rd = mode_reg_read_cmd;
  wire wr = mode_reg_write_cmd;
  property p_rv; rd |=> rd_valid && rd_strobe_toggle; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_nrv; !rd |=> !rd_valid; endproperty
  a_nrv: assert property (p_nrv) else $error("answer without read");
  property p_stb; rd && reg_index == 8'h01 |=> rd_strobe_toggle && rd_data == 8'h00; endproperty
  a_stb: assert property (p_stb) else $error("write-only read wrong");
  property p_res; rd && reg_index == 8'h00 |=> rd_data[7:5] == 3'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bits not zero");
  property p_una; rd && reg_index > 8'h3f |=> rd_data == 8'h00; endproperty
  a_una: assert property (p_una) else $error("unassigned read wrong");
  property p_wo; wr && reg_index == 8'h01 |=> device_feature_one == $past(wr_data); endproperty
  a_wo: assert property (p_wo) else $error("write not stored");
  property p_ro; wr && reg_index == 8'h00 |=> $stable(device_feature_one); endproperty
  a_ro: assert property (p_ro) else $error("read-only write had effect");
  property p_rst; wr && reg_index == 8'h3f |=> reset_pulse && auto_init_busy ##1 !reset_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("reset write ignored");
  c_rd: cover property (rd && reg_index == 8'h00);
  c_rst: cover property (reset_pulse);
  c_busy: cover property ($fell(auto_init_busy));
endmodule // mrb_monitor
`default_nettype wire

/* tb/mrb_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mrb_ctrl_model
(
  output var logic       rd,
  output var logic       wr,
  output var logic [7:0] idx,
  output var logic [7:0] wd,
  input wire logic       mclk
);
  initial {rd, wr, idx, wd} = 18'h0;
  task op(input logic r, input logic w, input logic [7:0] i, input logic [7:0] d);
    @(negedge mclk);
    rd <= r;
    wr <= w;
    idx <= i;
    wd <= d;
    @(negedge mclk);
    rd <= 1'b0;
    wr <= 1'b0;
    // released lines flip so stale values never pass
    idx <= ~i;
    wd <= ~d;
  endtask
endmodule // mrb_ctrl_model
`default_nettype wire

/* tb/mode_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mode_register_bank_tb;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] refresh_status = 8'h00;
  wire        mode_reg_read_cmd, mode_reg_write_cmd, rd_valid, rd_strobe_toggle;
  wire        auto_init_busy, reset_pulse, zq_cal_start;
  wire  [7:0] reg_index, wr_data, rd_data, device_feature_one, device_feature_two;
  wire  [7:0] io_configuration, vendor_test_mode, partial_array_bank_mask;
  wire  [7:0] partial_array_segment_mask;
  int         err_count = 0;
  int         tests_run = 0;
  logic [7:0] d;
  logic [1:0] zq = 2'h0;
  logic [7:0] tbl [11] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28, 8'h01,
                           8'h0b, 8'hff};
  logic [7:0] wo_tbl [6] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h10, 8'h11};
  always #10 mclk = ~mclk;
  mrb_ctrl_model u_ctl (.mclk, .rd(mode_reg_read_cmd), .wr(mode_reg_write_cmd),
                        .idx(reg_index), .wd(wr_data));
  mrb_mode_register_bank #(.init_cycles(16'd8), .zq_cycles(16'd4)) DUT (.mclk, .rst_b,
    .mode_reg_read_cmd, .mode_reg_write_cmd, .reg_index, .wr_data, .refresh_status, .rd_valid,
    .rd_data, .rd_strobe_toggle, .auto_init_busy, .reset_pulse, .device_feature_one,
    .device_feature_two, .io_configuration, .vendor_test_mode, .partial_array_bank_mask,
    .partial_array_segment_mask, .zq_cal_start);
  function automatic logic [7:0] ref_rd(input logic [7:0] a, input logic busy);
    case (a)
      8'h00: ref_rd = {3'h0, zq, 2'h0, busy};
      8'h04: ref_rd = refresh_status;
      8'h05: ref_rd = 8'h5a;
      8'h06: ref_rd = 8'h01;
      8'h08: ref_rd = 8'h14;
      8'h20: ref_rd = 8'h55;
      8'h28: ref_rd = 8'h3c;
      default: ref_rd = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] cfg_out(input logic [7:0] a);
    case (a)
      8'h01: cfg_out = device_feature_one;
      8'h02: cfg_out = device_feature_two;
      8'h03: cfg_out = io_configuration;
      8'h09: cfg_out = vendor_test_mode;
      8'h10: cfg_out = partial_array_bank_mask;
      default: cfg_out = partial_array_segment_mask;
    endcase
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t mismatch %h expected %h", $time, seen, exp);
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic busy);
    u_ctl.op(1'b1, 1'b0, a, 8'h00);
    chk({7'h0, rd_valid & rd_strobe_toggle}, 8'h01);
    chk(rd_data, ref_rd(a, busy));
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge mclk);
    err_count++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(11636));
    repeat (20) @(negedge mclk);
    rst_b <= 1'b1;
    rd_chk(8'h00, 1'b1);
    repeat (12) @(negedge mclk);
    foreach (tbl[i])
    begin
      refresh_status <= $urandom;
      rd_chk(tbl[i], 1'b0);
    end
    d = $urandom;
    u_ctl.op(1'b0, 1'b1, 8'h01, d);
    chk(device_feature_one, d);
    u_ctl.op(1'b0, 1'b1, 8'h00, ~d);
    chk(device_feature_one, d);
    foreach (wo_tbl[i])
    begin
      d = $urandom;
      u_ctl.op(1'b0, 1'b1, wo_tbl[i], d);
      chk(cfg_out(wo_tbl[i]), d);
    end
    u_ctl.op(1'b0, 1'b1, 8'h0a, $urandom);
    chk({7'h0, zq_cal_start}, 8'h01);
    repeat (10) @(negedge mclk);
    zq = 2'h3;
    rd_chk(8'h00, 1'b0);
    repeat (20)
    begin
      refresh_status <= $urandom;
      rd_chk($urandom, 1'b0);
    end
    u_ctl.op(1'b0, 1'b1, 8'h3f, 8'h00);
    chk({6'h0, reset_pulse, auto_init_busy}, 8'h03);
    chk(device_feature_one, 8'h22);
    foreach (wo_tbl[i])
      chk(cfg_out(wo_tbl[i]), (i == 0) ? 8'h22 : 8'h00);
    zq = 2'h0;
    rd_chk(8'h00, 1'b1);
    repeat (12) @(negedge mclk);
    rd_chk(8'h00, 1'b0);
    wrap_up;
  end
endmodule // mode_register_bank_tb
bind mrb_mode_register_bank mrb_monitor u_mon (.mclk, .rst_b, .mode_reg_read_cmd,
  .mode_reg_write_cmd, .reg_index, .wr_data, .rd_valid, .rd_data, .rd_strobe_toggle,
  .auto_init_busy, .reset_pulse, .device_feature_one);
`default_nettype wire
